// ### i2c_switch_pkg.sv
// Shared constants and types of the four-channel switch control block
package i2c_switch_pkg;

    // ------------------------------------------------------------------
    // Register layout
    // ------------------------------------------------------------------
    localparam int         CHAN_COUNT   = 4;        // Downstream channels
    localparam int         ENABLE_LSB   = 0;        // Channel enable field
    localparam int         STATUS_LSB   = 4;        // Interrupt status field
    localparam logic [7:0] CTRL_RESET   = 8'h00;    // Value after reset
    localparam logic [3:0] ENABLE_RESET = 4'h0;     // No channel selected

    // ------------------------------------------------------------------
    // Serial framing
    // ------------------------------------------------------------------
    localparam logic [3:0] BIT_CNT_ZERO  = 4'h0;    // Bit counter start
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;    // Bits before acknowledge
    localparam logic [4:0] ADDR_FIXED_DEFAULT = 5'h15; // Arbitrary fixed part

    // ------------------------------------------------------------------
    // Input synchroniser lanes
    // ------------------------------------------------------------------
    localparam int         SYNC_WIDTH   = 9;        // Lanes through the synchroniser
    localparam int         LANE_SCL     = 0;
    localparam int         LANE_SDA     = 1;
    localparam int         LANE_IRQ0    = 2;        // Four interrupt lanes from here
    localparam int         LANE_RST_N   = 6;
    localparam int         LANE_STRAP0  = 7;
    localparam int         LANE_STRAP1  = 8;
    localparam logic [8:0] SYNC_RESET   = 9'h07f;   // Idle levels: lines high, straps low

    // ------------------------------------------------------------------
    // Serial state machine
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE      = 3'b000,   // Not addressed, waiting for a start
        ST_ADDR      = 3'b001,   // Shifting in the address byte
        ST_ADDR_ACK  = 3'b010,   // Acknowledging our address
        ST_WRITE     = 3'b011,   // Shifting in a data byte
        ST_WRITE_ACK = 3'b100,   // Acknowledging a data byte
        ST_READ      = 3'b101,   // Shifting out the register
        ST_READ_ACK  = 3'b110    // Sampling the master's acknowledge
    } serial_state_t;

endpackage : i2c_switch_pkg

// ### sync_2ff.sv
// Two-flop synchroniser for a vector of independent levels
`timescale 1ns/1ps

module sync_2ff #(
    parameter int               WIDTH   = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    // Clock and reset
    input  wire logic             clk_in,
    input  wire logic             rst_in,
    // Levels
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    // ------------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------------
    if (WIDTH < 1) begin : g_width_check
        $error("sync_2ff needs at least one lane");
    end

    logic [WIDTH-1:0] meta_q;   // First stage, read only by the second
    logic [WIDTH-1:0] sync_q;   // Second stage, safe to use

    // Both stages load constants under reset
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            meta_q <= RST_VAL;
            sync_q <= RST_VAL;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;

endmodule : sync_2ff

// ### i2c_switch_ctrl.sv
// Serial slave and control register of the four-channel switch
`timescale 1ns/1ps

// Function
// - Bit n enables channel n, one enables
// - Any enable combination connects simultaneously
// - Reset default selects no channel
// - Four low interrupt inputs, one open-drain output
// - Any low input pulls output low
// - Interrupts detected on deselected channels too
// - Bits 4-7 show channels 0-3 status
// - Read captures current interrupt input levels
// - Status one means pending, several allowed
// - Interrupt inputs usable as sampled general inputs
// - Two straps set low address bits
// - Multi-byte write keeps only last byte
// - New selection applies at stop condition
// - Address LSB one reads, zero writes
// - Power-on clears everything; reset pin clears enables and serial state
module i2c_switch_ctrl #(
    parameter logic [4:0] ADDR_FIXED = i2c_switch_pkg::ADDR_FIXED_DEFAULT
) (
    // Clock and power-on reset
    input  wire logic clk_in,
    input  wire logic rst_in,
    // Reset pin
    input  wire logic reset_pin_in_n,
    // Address straps
    input  wire logic addr_strap_0_in,
    input  wire logic addr_strap_1_in,
    // Upstream serial bus
    input  wire logic scl_in,
    input  wire logic sda_in,
    output logic      sda_out,
    output logic      sda_oe_out,
    // Channel interrupt inputs
    input  wire logic chan0_irq_in_n,
    input  wire logic chan1_irq_in_n,
    input  wire logic chan2_irq_in_n,
    input  wire logic chan3_irq_in_n,
    // Shared open-drain interrupt output
    output logic      irq_out,
    output logic      irq_oe_out,
    // Downstream channel enables
    output logic      chan0_enable_out,
    output logic      chan1_enable_out,
    output logic      chan2_enable_out,
    output logic      chan3_enable_out
);

    // ------------------------------------------------------------------
    // Input synchronisation
    // ------------------------------------------------------------------
    logic [i2c_switch_pkg::SYNC_WIDTH-1:0] pins_raw;    // Pins as they arrive
    logic [i2c_switch_pkg::SYNC_WIDTH-1:0] pins_sync;   // Pins after two flops

    assign pins_raw = {addr_strap_1_in, addr_strap_0_in, reset_pin_in_n,
                       chan3_irq_in_n, chan2_irq_in_n, chan1_irq_in_n,
                       chan0_irq_in_n, sda_in, scl_in};

    sync_2ff #(
        .WIDTH   (i2c_switch_pkg::SYNC_WIDTH),
        .RST_VAL (i2c_switch_pkg::SYNC_RESET)
    ) u_sync (
        .clk_in   (clk_in),
        .rst_in   (rst_in),
        .async_in (pins_raw),
        .sync_out (pins_sync)
    );

    logic       scl_s;       // Synchronised clock line
    logic       sda_s;       // Synchronised data line
    logic [3:0] irq_n_s;     // Synchronised interrupt inputs, channel order
    logic       pin_clr;     // Reset pin held low

    assign scl_s   = pins_sync[i2c_switch_pkg::LANE_SCL];
    assign sda_s   = pins_sync[i2c_switch_pkg::LANE_SDA];
    assign irq_n_s = pins_sync[i2c_switch_pkg::LANE_IRQ0 +: i2c_switch_pkg::CHAN_COUNT];
    assign pin_clr = ~pins_sync[i2c_switch_pkg::LANE_RST_N];

    // ------------------------------------------------------------------
    // Bus condition detection
    // ------------------------------------------------------------------
    logic scl_prev_q;   // Clock line one sample ago
    logic sda_prev_q;   // Data line one sample ago

    // Previous samples for edge finding
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
        end else begin
            scl_prev_q <= scl_s;
            sda_prev_q <= sda_s;
        end
    end

    logic scl_rise;     // Clock line went high
    logic scl_fall;     // Clock line went low
    logic start_det;    // Data fell while clock high
    logic stop_det;     // Data rose while clock high

    assign scl_rise  = scl_s & ~scl_prev_q;
    assign scl_fall  = ~scl_s & scl_prev_q;
    assign start_det = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
    assign stop_det  = scl_s & scl_prev_q & ~sda_prev_q & sda_s;

    // ------------------------------------------------------------------
    // Own address
    // ------------------------------------------------------------------
    logic [1:0] strap_q;    // Strap levels, resampled every clock after reset release

    // Straps are sampled continuously by the clock, never by the reset
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            strap_q <= 2'b00;
        end else begin
            strap_q <= {pins_sync[i2c_switch_pkg::LANE_STRAP1],
                        pins_sync[i2c_switch_pkg::LANE_STRAP0]};
        end
    end

    logic [6:0] own_addr;   // Seven-bit slave address
    assign own_addr = {ADDR_FIXED, strap_q};

    // ------------------------------------------------------------------
    // Register contents
    // ------------------------------------------------------------------
    logic [3:0] enable_q;   // Channel enables driving the switches
    logic [3:0] status;     // Live interrupt status, one means pending
    logic [7:0] read_byte;  // Register as presented to a read

    assign status    = ~irq_n_s;
    assign read_byte = {status, enable_q};

    // ------------------------------------------------------------------
    // Serial state machine
    // ------------------------------------------------------------------
    i2c_switch_pkg::serial_state_t state_q;  // Current phase
    logic [3:0] bit_cnt_q;   // Bits handled in this byte
    logic [7:0] shift_q;     // Incoming byte
    logic [7:0] tx_q;        // Outgoing byte, MSB first
    logic       rw_q;        // Direction from the address byte
    logic       ack_q;       // Master acknowledged the last read byte
    logic       sda_oe_q;    // Pulling the data line low

    logic byte_in_done;      // Eighth bit of a received byte has ended
    assign byte_in_done = scl_fall & (bit_cnt_q == i2c_switch_pkg::BITS_PER_BYTE);

    // Framing, shifting and data line drive
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_q   <= i2c_switch_pkg::ST_IDLE;
            bit_cnt_q <= i2c_switch_pkg::BIT_CNT_ZERO;
            shift_q   <= i2c_switch_pkg::CTRL_RESET;
            tx_q      <= i2c_switch_pkg::CTRL_RESET;
            rw_q      <= 1'b0;
            ack_q     <= 1'b0;
            sda_oe_q  <= 1'b0;
        end else if (pin_clr) begin
            // Pin reset returns the machine to zeros
            state_q   <= i2c_switch_pkg::ST_IDLE;
            bit_cnt_q <= i2c_switch_pkg::BIT_CNT_ZERO;
            shift_q   <= i2c_switch_pkg::CTRL_RESET;
            tx_q      <= i2c_switch_pkg::CTRL_RESET;
            rw_q      <= 1'b0;
            ack_q     <= 1'b0;
            sda_oe_q  <= 1'b0;
        end else if (start_det) begin
            // Start or repeated start: expect an address
            state_q   <= i2c_switch_pkg::ST_ADDR;
            bit_cnt_q <= i2c_switch_pkg::BIT_CNT_ZERO;
            sda_oe_q  <= 1'b0;
        end else if (stop_det) begin
            // Stop ends any transfer
            state_q   <= i2c_switch_pkg::ST_IDLE;
            sda_oe_q  <= 1'b0;
        end else begin
            unique case (state_q)
                i2c_switch_pkg::ST_IDLE: begin
                    sda_oe_q <= 1'b0;
                end
                i2c_switch_pkg::ST_ADDR: begin
                    if (scl_rise) begin
                        shift_q   <= {shift_q[6:0], sda_s};
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                    end
                    if (byte_in_done) begin
                        if (shift_q[7:1] == own_addr) begin
                            rw_q     <= shift_q[0];
                            sda_oe_q <= 1'b1;
                            state_q  <= i2c_switch_pkg::ST_ADDR_ACK;
                        end else begin
                            // Someone else's address: stay off the bus
                            state_q  <= i2c_switch_pkg::ST_IDLE;
                        end
                    end
                end
                i2c_switch_pkg::ST_ADDR_ACK: begin
                    if (scl_fall) begin
                        if (rw_q) begin
                            // Snapshot of inputs taken as the read begins
                            tx_q      <= read_byte;
                            sda_oe_q  <= ~read_byte[7];
                            bit_cnt_q <= 4'h1;
                            state_q   <= i2c_switch_pkg::ST_READ;
                        end else begin
                            sda_oe_q  <= 1'b0;
                            bit_cnt_q <= i2c_switch_pkg::BIT_CNT_ZERO;
                            state_q   <= i2c_switch_pkg::ST_WRITE;
                        end
                    end
                end
                i2c_switch_pkg::ST_WRITE: begin
                    if (scl_rise) begin
                        shift_q   <= {shift_q[6:0], sda_s};
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                    end
                    if (byte_in_done) begin
                        sda_oe_q <= 1'b1;
                        state_q  <= i2c_switch_pkg::ST_WRITE_ACK;
                    end
                end
                i2c_switch_pkg::ST_WRITE_ACK: begin
                    if (scl_fall) begin
                        sda_oe_q  <= 1'b0;
                        bit_cnt_q <= i2c_switch_pkg::BIT_CNT_ZERO;
                        state_q   <= i2c_switch_pkg::ST_WRITE;
                    end
                end
                i2c_switch_pkg::ST_READ: begin
                    if (scl_fall) begin
                        if (bit_cnt_q == i2c_switch_pkg::BITS_PER_BYTE) begin
                            // Release for the master's acknowledge
                            sda_oe_q <= 1'b0;
                            state_q  <= i2c_switch_pkg::ST_READ_ACK;
                        end else begin
                            tx_q      <= {tx_q[6:0], 1'b0};
                            sda_oe_q  <= ~tx_q[6];
                            bit_cnt_q <= bit_cnt_q + 4'h1;
                        end
                    end
                end
                i2c_switch_pkg::ST_READ_ACK: begin
                    if (scl_rise) begin
                        ack_q <= ~sda_s;
                    end
                    if (scl_fall) begin
                        if (ack_q) begin
                            // Further byte: fresh snapshot of the register
                            tx_q      <= read_byte;
                            sda_oe_q  <= ~read_byte[7];
                            bit_cnt_q <= 4'h1;
                            state_q   <= i2c_switch_pkg::ST_READ;
                        end else begin
                            // Not acknowledged: wait for the stop
                            state_q   <= i2c_switch_pkg::ST_IDLE;
                        end
                    end
                end
                default: begin
                    state_q  <= i2c_switch_pkg::ST_IDLE;
                    sda_oe_q <= 1'b0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Written byte held until stop
    // ------------------------------------------------------------------
    logic [3:0] pending_q;      // Last enable field received
    logic       pending_vld_q;  // A byte arrived since the last stop

    // Each new byte overwrites the previous one
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            pending_q     <= i2c_switch_pkg::ENABLE_RESET;
            pending_vld_q <= 1'b0;
        end else if (pin_clr) begin
            pending_q     <= i2c_switch_pkg::ENABLE_RESET;
            pending_vld_q <= 1'b0;
        end else if (stop_det) begin
            pending_vld_q <= 1'b0;
        end else if (state_q == i2c_switch_pkg::ST_WRITE && byte_in_done) begin
            // Status bits of the byte are read-only and dropped
            pending_q     <= shift_q[i2c_switch_pkg::ENABLE_LSB +: 4];
            pending_vld_q <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Channel enables
    // ------------------------------------------------------------------
    // Switches change only at a stop, when every line is high, or when the reset pin or power-on reset clears them
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            enable_q <= i2c_switch_pkg::ENABLE_RESET;
        end else if (pin_clr) begin
            enable_q <= i2c_switch_pkg::ENABLE_RESET;
        end else if (stop_det && pending_vld_q) begin
            enable_q <= pending_q;
        end
    end

    // ------------------------------------------------------------------
    // Shared interrupt output
    // ------------------------------------------------------------------
    logic irq_oe_q;     // Pulling the shared interrupt low

    // Any pending channel, selected or not, pulls the line
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            irq_oe_q <= 1'b0;
        end else begin
            irq_oe_q <= |status;
        end
    end

    // ------------------------------------------------------------------
    // Open-drain data levels
    // ------------------------------------------------------------------
    logic sda_lvl_q;    // Level driven when the data line is enabled
    logic irq_lvl_q;    // Level driven when the interrupt is enabled

    // Open-drain pins only ever drive low
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            sda_lvl_q <= 1'b0;
            irq_lvl_q <= 1'b0;
        end else begin
            sda_lvl_q <= 1'b0;
            irq_lvl_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign sda_out          = sda_lvl_q;
    assign sda_oe_out       = sda_oe_q;
    assign irq_out          = irq_lvl_q;
    assign irq_oe_out       = irq_oe_q;
    assign chan0_enable_out = enable_q[0];
    assign chan1_enable_out = enable_q[1];
    assign chan2_enable_out = enable_q[2];
    assign chan3_enable_out = enable_q[3];

endmodule : i2c_switch_ctrl

// ### switch_ctrl_asserts.sv
// Port checker of the four-channel switch control block
`timescale 1ns/1ps

module switch_checker (
    // Clock, reset and line inputs
    input wire logic clk_in, rst_in, reset_pin_in_n, scl_in, sda_in,
    input wire logic chan0_irq_in_n, chan1_irq_in_n, chan2_irq_in_n, chan3_irq_in_n,
    // Outputs of the block
    input wire logic sda_out, sda_oe_out, irq_out, irq_oe_out,
    input wire logic chan0_enable_out, chan1_enable_out, chan2_enable_out, chan3_enable_out
);
    // ------------------------------------------------------------------
    // Helper signals
    // ------------------------------------------------------------------
    logic [3:0] en;      // Channel enables as a vector
    logic       any_low; // Some channel interrupt pending
    assign en = {chan3_enable_out, chan2_enable_out, chan1_enable_out, chan0_enable_out};
    assign any_low = !(chan0_irq_in_n & chan1_irq_in_n & chan2_irq_in_n & chan3_irq_in_n);

    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);

    // Steady pending or idle interrupt inputs, and a reset pin held low
    sequence low_run; any_low [*5]; endsequence
    sequence high_run; !any_low [*5]; endsequence
    sequence pin_low; !reset_pin_in_n [*4]; endsequence

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    irq_pull_a: assert property (low_run |-> irq_oe_out)
        else $error("shared interrupt not pulled");
    irq_release_a: assert property (high_run |-> !irq_oe_out)
        else $error("shared interrupt not released");
    irq_cause_a: assert property ($rose(irq_oe_out) |->
        $past(any_low, 2) || $past(any_low, 3) || $past(any_low, 4))
        else $error("interrupt pulled without cause");
    drive_low_a: assert property (!irq_out && !sda_out)
        else $error("open-drain output drives high");
    pin_clear_a: assert property (pin_low |-> en == 4'h0)
        else $error("reset pin left a channel on");
    pin_quiet_a: assert property (pin_low |-> !sda_oe_out)
        else $error("reset pin left data line held");
    stop_apply_a: assert property ($changed(en) |-> scl_in && sda_in)
        else $error("enables changed away from stop");
    ack_phase_a: assert property ($changed(sda_oe_out) |-> !scl_in && !$past(scl_in, 2))
        else $error("data line changed while clock high");
endmodule : switch_checker

bind i2c_switch_ctrl switch_checker chk (.*);

// ### upstream_master.sv
// Upstream serial bus master model, open-drain on both lines
`timescale 1ns/1ps

module upstream_master (
    // Pacing clock and resolved data line
    input  wire logic clk_in,
    input  wire logic sda_in,
    // Pull-down enables of clock and data
    output logic      scl_oe_out,
    output logic      sda_oe_out
);
    // Both lines released: the pull-ups hold them high between frames
    initial begin
        scl_oe_out = 1'b0;
        sda_oe_out = 1'b0;
    end

    // Quarter of a 160 ns bit, stepped at the falling edge
    task automatic q();
        repeat (8) @(negedge clk_in);
    endtask : q

    // Start or repeated start
    task automatic start();
        sda_oe_out = 1'b0; q();
        scl_oe_out = 1'b0; q();
        sda_oe_out = 1'b1; q();
        scl_oe_out = 1'b1; q();
    endtask : start

    // Stop: data rises while clock high
    task automatic stop();
        sda_oe_out = 1'b1; q();
        scl_oe_out = 1'b0; q();
        sda_oe_out = 1'b0; q();
    endtask : stop

    // One bit, data set while clock low, sampled while high
    task automatic bit_x(input logic b, output logic r);
        sda_oe_out = !b; q();
        scl_oe_out = 1'b0; q();
        r = sda_in; q();
        scl_oe_out = 1'b1; q();
    endtask : bit_x

    // Byte MSB first plus acknowledge; mack drives our own acknowledge
    task automatic xfer(input logic [7:0] d, input logic mack,
                        output logic [7:0] r, output logic ack);
        logic a;
        for (int i = 7; i >= 0; i--) bit_x(d[i], r[i]);
        bit_x(!mack, a);
        ack = !a;
        sda_oe_out = 1'b0;
    endtask : xfer
endmodule : upstream_master

// ### testbench.sv
// Self-checking bench of the four-channel switch control block
`timescale 1ns/1ps

module testbench;
    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    logic       clk_in = 1'b0, rst_in = 1'b1, pin_n = 1'b1;
    logic [3:0] irq_n = 4'hf;                 // Channel interrupt levels
    logic [1:0] strap = 2'b10;                // Address strap levels, bit 1 first
    logic       m_scl_oe, m_sda_oe, d_sda_oe, d_irq_oe, d_sda, d_irq;
    wire  [3:0] en;                           // Channel enables
    wire        scl = !m_scl_oe;              // Pulled-up clock line
    wire        sda = !(m_sda_oe | (d_sda_oe & !d_sda)); // Pulled-up data line
    int         bad_count = 0, n_tests = 0;
    localparam logic [6:0] ADDR = {i2c_switch_pkg::ADDR_FIXED_DEFAULT, 2'b10};

    always #2.5 clk_in = !clk_in;

    upstream_master master (.clk_in(clk_in), .sda_in(sda), .scl_oe_out(m_scl_oe),
                            .sda_oe_out(m_sda_oe));
    i2c_switch_ctrl dut (.clk_in(clk_in), .rst_in(rst_in), .reset_pin_in_n(pin_n),
        .addr_strap_0_in(strap[0]), .addr_strap_1_in(strap[1]), .scl_in(scl), .sda_in(sda),
        .sda_out(d_sda), .sda_oe_out(d_sda_oe), .chan0_irq_in_n(irq_n[0]),
        .chan1_irq_in_n(irq_n[1]), .chan2_irq_in_n(irq_n[2]), .chan3_irq_in_n(irq_n[3]),
        .irq_out(d_irq), .irq_oe_out(d_irq_oe), .chan0_enable_out(en[0]),
        .chan1_enable_out(en[1]), .chan2_enable_out(en[2]), .chan3_enable_out(en[3]));

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            $display("BAD %0t got %h expected %h", $time, got, exp);
            bad_count++;
        end
    endtask : chk

    // Addressed write of two bytes, left open before the stop
    task automatic wr(input logic [7:0] b0, input logic [7:0] b1);
        logic [7:0] r;
        logic       a;
        master.start();
        master.xfer({ADDR, 1'b0}, 1'b0, r, a);
        chk({7'h0, a}, 8'h01);
        master.xfer(b0, 1'b0, r, a);
        master.xfer(b1, 1'b0, r, a);
    endtask : wr

    // Addressed read of two bytes: first acknowledged, second refused, then a stop
    task automatic rd(output logic [7:0] r);
        logic [7:0] r2;
        logic       a;
        master.start();
        master.xfer({ADDR, 1'b1}, 1'b0, r, a);
        chk({7'h0, a}, 8'h01);
        master.xfer(8'hff, 1'b1, r, a);
        master.xfer(8'hff, 1'b0, r2, a);
        chk(r2, r);
        master.stop();
    endtask : rd

    task automatic settle();
        repeat (8) @(negedge clk_in);
    endtask : settle

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_select();
        logic [3:0] prev;
        logic [7:0] r;
        for (int v = 0; v < 16; v++) begin
            prev = en;
            wr(~v[7:0], {4'ha, v[3:0]});
            chk({4'h0, en}, {4'h0, prev});
            master.stop();
            settle();
            chk({4'h0, en}, {4'h0, v[3:0]});
            rd(r);
            chk(r, {4'h0, v[3:0]});
        end
        $display("t_select done");
    endtask : t_select

    task automatic t_addr();
        logic [7:0] r;
        logic       a;
        // Pass 0: foreign address ignored; pass 1: straps moved so it is ours
        for (int k = 0; k < 2; k++) begin
            master.start();
            master.xfer({ADDR ^ 7'h03, 1'b0}, 1'b0, r, a);
            chk({7'h0, a}, 8'(k));
            master.xfer(8'h03, 1'b0, r, a);
            master.stop();
            settle();
            chk({4'h0, en}, (k == 0) ? 8'h0f : 8'h03);
            strap = (k == 0) ? 2'b01 : 2'b10;
            settle();
        end
        $display("t_addr done");
    endtask : t_addr

    task automatic t_pin();
        pin_n = 1'b0;
        repeat (6) @(negedge clk_in);
        pin_n = 1'b1;
        settle();
        chk({4'h0, en}, 8'h00);
        $display("t_pin done");
    endtask : t_pin

    task automatic t_irq();
        logic [7:0] r;
        irq_n = 4'b1001;
        settle();
        chk({7'h0, d_irq_oe}, 8'h01);
        rd(r);
        chk(r, 8'h60);
        wr(8'h06, 8'h06);
        master.stop();
        irq_n = 4'b1011;
        settle();
        chk({4'h0, en}, 8'h06);
        chk({7'h0, d_irq_oe}, 8'h01);
        rd(r);
        chk(r, 8'h46);
        irq_n = 4'hf;
        settle();
        chk({7'h0, d_irq_oe}, 8'h00);
        $display("t_irq done");
    endtask : t_irq

    // ------------------------------------------------------------------
    // Verdict, main sequence and watchdog
    // ------------------------------------------------------------------
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : summarize

    initial begin
        repeat (6) @(negedge clk_in);
        rst_in = 1'b0;
        settle();
        chk({d_sda, d_irq, d_sda_oe, d_irq_oe, en}, 8'h00);
        t_select();
        t_addr();
        t_pin();
        t_irq();
        summarize();
    end

    initial begin
        repeat (60000) @(posedge clk_in);
        bad_count++;
        summarize();
    end
endmodule : testbench
